/* File: fault_summary_pkg.sv */
// shared constants and carriers for the fault summary register block
// assumes a single core clock and a command port fed by the serial management front end
package fault_summary_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0]  CMD_OUTPUT_FALL_TIME    = 8'h65;
  localparam logic [7:0]  CMD_FAULT_SUMMARY_BYTE  = 8'h78;
  localparam logic [7:0]  CMD_FAULT_SUMMARY_WORD  = 8'h79;
  // code of the commit-settings command; value is arbitrary
  localparam logic [7:0]  CMD_COMMIT_SETTINGS     = 8'he7;

  // ==========================================================================
  // sizes and reset values
  localparam int          NUM_OUTPUTS             = 2;
  localparam logic [15:0] OUTPUT_FALL_TIME_RESET  = 16'h01f4;

  // ==========================================================================
  // bit positions in the summary byte and word
  localparam int          SUM_OTHER_CHANGE_BIT    = 0;
  localparam int          SUM_COMM_MEM_LOGIC_BIT  = 1;
  localparam int          SUM_TEMPERATURE_BIT     = 2;
  localparam int          SUM_INPUT_UV_BIT        = 3;
  localparam int          SUM_OUTPUT_OC_BIT       = 4;
  localparam int          SUM_OUTPUT_OV_BIT       = 5;
  localparam int          SUM_OFF_BIT             = 6;
  localparam int          SUM_NOT_POWER_GOOD_BIT  = 11;
  localparam int          SUM_VENDOR_EVENT_BIT    = 12;
  localparam int          SUM_INPUT_VOLTAGE_BIT   = 13;
  localparam int          SUM_OUTPUT_CURRENT_BIT  = 14;
  localparam int          SUM_OUTPUT_VOLTAGE_BIT  = 15;

  // detailed status of one output page
  typedef struct packed {
    logic off;               // not delivering power, for any reason
    logic power_good;        // power-good level of this output
    logic vout_ov;           // output overvoltage fault
    logic vout_uv;           // output undervoltage fault
    logic vout_max_warn;     // output voltage maximum warning
    logic output_current_summary_flag_oc;           // output overcurrent fault
    logic output_current_summary_flag_oc_uv;        // overcurrent with undervoltage fault
    logic output_current_summary_flag_share;        // current share fault
  } output_status_t;

  // detailed status common to the whole unit
  typedef struct packed {
    logic       vin_ov;      // input overvoltage fault
    logic       vin_uv;      // input undervoltage fault
    logic       temp_ot_fault;
    logic       temp_ot_warn;
    logic       temp_ut_fault;
    logic [7:0] comm_mem_logic; // detailed communication, memory, logic bits
    logic       vendor_event;
    logic       other_change;
  } unit_status_t;

  // one command from the serial front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        page;
    logic [7:0]  code;
    logic [15:0] wdata;
  } command_t;

  // answer to a read command
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } response_t;

endpackage : fault_summary_pkg

/* File: fall_time_slot.sv */
// one output page of the fall-time setting: written value and committed value
// assumes writes and commits arrive as one-cycle strobes on the core clock
module fall_time_slot (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        write_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        commit_i,
  output logic [15:0]      setting_o,
  output logic [15:0]      active_o
);
  import fault_summary_pkg::*;

  // ==========================================================================
  // written value, read back by the host at once
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      setting_o <= OUTPUT_FALL_TIME_RESET;
    end else if (write_i) begin
      setting_o <= wdata_i;
    end
  end

  // ==========================================================================
  // value the ramp uses; a write alone never reaches it
  // a write and commit in the same cycle commit the new value
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= OUTPUT_FALL_TIME_RESET;
    end else if (commit_i) begin
      active_o <= write_i ? wdata_i : setting_o;
    end
  end

endmodule // fall_time_slot

/* File: fault_status_summary.sv */
// fall-time setting per output page and global fault summary byte and word
// assumes a serial management front end hands over decoded commands, one per cycle at most
//
// Operation
// - old fall time stays in use until the commit command follows a write
// - fall time is per page, sixteen bit read/write, resets to 01f4h
// - global read-only summary byte reflects faults of either output
// - bit 6 set whenever an output delivers no power, for any reason
// - bit 5 overvoltage, bit 4 overcurrent, bit 3 input undervoltage
// - bit 2 any temperature fault or warning, bit 1 communication memory logic
// - bit 0 for other status changes, byte bit 7 unused
// - low byte of the summary word equals the summary byte
// - summary word is global, read-only, two bytes, covers either output
// - word bits 15, 14, 13: output voltage, output current, input voltage
// - word bit 12 set when a vendor specific event occurred
// - word bit 11 set while power-good is negated
module fault_status_summary (
  input  wire logic                              core_clk_i,
  input  wire logic                              rst_i,
  input  wire fault_summary_pkg::command_t       command_i,
  input  wire fault_summary_pkg::output_status_t output0_status_i,
  input  wire fault_summary_pkg::output_status_t output1_status_i,
  input  wire fault_summary_pkg::unit_status_t   unit_status_i,
  output fault_summary_pkg::response_t           response_o,
  output logic [15:0]                            fall_time0_o,
  output logic [15:0]                            fall_time1_o,
  output logic [7:0]                             fault_summary_byte_o,
  output logic [15:0]                            fault_summary_word_o,
  output logic                                   write_refused_o
);
  import fault_summary_pkg::*;

  // ==========================================================================
  // declarations
  output_status_t          page_status [NUM_OUTPUTS];
  logic [NUM_OUTPUTS-1:0]  slot_write;
  logic [15:0]             slot_setting [NUM_OUTPUTS];
  logic [15:0]             slot_active [NUM_OUTPUTS];
  logic                    commit_strobe;
  logic [7:0]              next_summary_byte;
  logic [15:0]             next_summary_word;
  logic [NUM_OUTPUTS-1:0]  any_off;
  logic [NUM_OUTPUTS-1:0]  any_ov;
  logic [NUM_OUTPUTS-1:0]  any_oc;
  logic [NUM_OUTPUTS-1:0]  any_vout;
  logic [NUM_OUTPUTS-1:0]  any_output_current_summary_flag;
  logic [NUM_OUTPUTS-1:0]  any_not_good;
  response_t               next_response;
  logic                    next_refused;

  assign page_status[0] = output0_status_i;
  assign page_status[1] = output1_status_i;

  // ==========================================================================
  // command decode for writes
  // the commit reaches every page: the ramp of either output follows the same command
  assign commit_strobe = command_i.valid && command_i.write
                         && (command_i.code == CMD_COMMIT_SETTINGS);

  // ==========================================================================
  // one fall-time slot per output page
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_page
      // a write lands only in the slot of the addressed page
      assign slot_write[gi] = command_i.valid && command_i.write
                              && (command_i.code == CMD_OUTPUT_FALL_TIME)
                              && (command_i.page == 1'(gi));

      fall_time_slot u_slot (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .write_i    (slot_write[gi]),
        .wdata_i    (command_i.wdata),
        .commit_i   (commit_strobe),
        .setting_o  (slot_setting[gi]),
        .active_o   (slot_active[gi])
      );

      // per-page category terms, gathered across pages below
      assign any_off[gi]      = page_status[gi].off;
      assign any_ov[gi]       = page_status[gi].vout_ov;
      assign any_oc[gi]       = page_status[gi].output_current_summary_flag_oc;
      assign any_vout[gi]     = page_status[gi].vout_ov | page_status[gi].vout_uv
                                | page_status[gi].vout_max_warn;
      assign any_output_current_summary_flag[gi]     = page_status[gi].output_current_summary_flag_oc | page_status[gi].output_current_summary_flag_oc_uv
                                | page_status[gi].output_current_summary_flag_share;
      assign any_not_good[gi] = ~page_status[gi].power_good;
    end
  endgenerate

  // ==========================================================================
  // summary byte: category bits ORed over both outputs, unused bits zero
  always_comb begin
    next_summary_byte                         = 8'h00;
    next_summary_byte[SUM_OFF_BIT]            = |any_off;
    next_summary_byte[SUM_OUTPUT_OV_BIT]      = |any_ov;
    next_summary_byte[SUM_OUTPUT_OC_BIT]      = |any_oc;
    next_summary_byte[SUM_INPUT_UV_BIT]       = unit_status_i.vin_uv;
    next_summary_byte[SUM_TEMPERATURE_BIT]    = unit_status_i.temp_ot_fault
                                                | unit_status_i.temp_ot_warn
                                                | unit_status_i.temp_ut_fault;
    next_summary_byte[SUM_COMM_MEM_LOGIC_BIT] = |unit_status_i.comm_mem_logic;
    next_summary_byte[SUM_OTHER_CHANGE_BIT]   = unit_status_i.other_change;
  end

  // ==========================================================================
  // summary word: low byte is the byte summary itself, so they never disagree
  always_comb begin
    next_summary_word                         = 16'h0000;
    next_summary_word[7:0]                    = next_summary_byte;
    next_summary_word[SUM_OUTPUT_VOLTAGE_BIT] = |any_vout;
    next_summary_word[SUM_OUTPUT_CURRENT_BIT] = |any_output_current_summary_flag;
    next_summary_word[SUM_INPUT_VOLTAGE_BIT]  = unit_status_i.vin_ov
                                                | unit_status_i.vin_uv;
    next_summary_word[SUM_VENDOR_EVENT_BIT]   = unit_status_i.vendor_event;
    next_summary_word[SUM_NOT_POWER_GOOD_BIT] = |any_not_good;
  end

  // ==========================================================================
  // registered summaries; the detailed sources hold their own sticky state,
  // so this block follows them with one cycle of latency and keeps no history
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_summary_byte_o <= 8'h00;
      fault_summary_word_o <= 16'h0000;
    end else begin
      fault_summary_byte_o <= next_summary_byte;
      fault_summary_word_o <= next_summary_word;
    end
  end

  // ==========================================================================
  // read answers; summaries are global, so the page field is ignored for them
  // reads return the live value, registered like the byte output, so the host sees the same bits as the byte output in the same cycle
  always_comb begin
    next_response       = '0;
    next_response.valid = command_i.valid && !command_i.write;
    if (command_i.valid && !command_i.write) begin
      unique case (command_i.code)
        CMD_OUTPUT_FALL_TIME: begin
          next_response.data = slot_setting[command_i.page];
        end
        CMD_FAULT_SUMMARY_BYTE: begin
          next_response.data = {8'h00, next_summary_byte};
        end
        CMD_FAULT_SUMMARY_WORD: begin
          next_response.data = next_summary_word;
        end
        default: begin
          next_response.error = 1'b1;                                    // unmapped code
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      response_o <= '0;
    end else begin
      response_o <= next_response;
    end
  end

  // ==========================================================================
  // writes to the read-only summaries or to unknown codes are dropped and flagged
  always_comb begin
    next_refused = 1'b0;
    if (command_i.valid && command_i.write) begin
      next_refused = !((command_i.code == CMD_OUTPUT_FALL_TIME)
                       || (command_i.code == CMD_COMMIT_SETTINGS));
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_refused_o <= 1'b0;
    end else begin
      write_refused_o <= next_refused;
    end
  end

  // ==========================================================================
  // committed fall times to the ramp generators; registered again so the
  // outputs come from flops here; the ramp sees a commit two cycles after it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_time0_o <= OUTPUT_FALL_TIME_RESET;
      fall_time1_o <= OUTPUT_FALL_TIME_RESET;
    end else begin
      fall_time0_o <= slot_active[0];
      fall_time1_o <= slot_active[1];
    end
  end

endmodule // fault_status_summary

/* File: fault_status_summary_assertions.sv */
// checker for the fault summary block, sees only its top module ports
// assumes one core clock and an active high asynchronous reset
module fault_status_summary_checker
  import fault_summary_pkg::*;
(
  input wire logic                              core_clk_i,
  input wire logic                              rst_i,
  input wire fault_summary_pkg::command_t       command_i,
  input wire fault_summary_pkg::output_status_t output0_status_i,
  input wire fault_summary_pkg::output_status_t output1_status_i,
  input wire fault_summary_pkg::unit_status_t   unit_status_i,
  input wire fault_summary_pkg::response_t      response_o,
  input wire logic [15:0]                       fall_time0_o,
  input wire logic [15:0]                       fall_time1_o,
  input wire logic [7:0]                        fault_summary_byte_o,
  input wire logic [15:0]                       fault_summary_word_o,
  input wire logic                              write_refused_o
);
  // ==========================================================================
  // expected summary from the live inputs, bits ORed over both pages
  logic [7:0]  any_out;
  logic [14:0] u;
  logic [15:0] exp_word;
  logic        rd_cmd;
  assign any_out  = output0_status_i | output1_status_i;
  assign u        = unit_status_i;
  assign exp_word = {|any_out[5:3], |any_out[2:0], u[14] | u[13], u[1],
                     ~(output0_status_i.power_good & output1_status_i.power_good), 4'h0,
                     any_out[7], any_out[5], any_out[2], u[13], |u[12:10], |u[9:2], u[0]};
  assign rd_cmd   = command_i.valid & ~command_i.write;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // summary relations
  a_byte_in_word: assert property (
    fault_summary_byte_o == fault_summary_word_o[7:0]) else $error("byte and word low differ");
  a_unused_zero: assert property (
    fault_summary_word_o[10:7] == 4'h0) else $error("unused word bits set");
  a_byte_bits: assert property (
    !$past(rst_i) |-> fault_summary_byte_o == $past(exp_word[7:0]))
    else $error("summary byte wrong");
  a_word_high: assert property (
    !$past(rst_i) |-> fault_summary_word_o[15:11] == $past(exp_word[15:11]))
    else $error("summary word high bits wrong");
  a_read_word: assert property (
    rd_cmd && command_i.code == 8'h79 |=> response_o.valid && !response_o.error
      && response_o.data == $past(exp_word)) else $error("word read wrong");
  a_read_byte: assert property (
    rd_cmd && command_i.code == 8'h78 |=> response_o.valid
      && response_o.data == {8'h00, $past(exp_word[7:0])}) else $error("byte read wrong");
  a_bad_read: assert property (
    rd_cmd && !(command_i.code inside {8'h65, 8'h78, 8'h79, 8'he7}) |=> response_o.valid
      && response_o.error && response_o.data == 16'h0000) else $error("unmapped read wrong");
  a_refused_write: assert property (
    command_i.valid && command_i.write && command_i.code inside {8'h78, 8'h79}
      |=> write_refused_o) else $error("read-only write not refused");
  a_commit_only: assert property (
    $changed(fall_time0_o) || $changed(fall_time1_o) |->
      $past(command_i.valid && command_i.code == 8'he7, 2)) else $error("fall time moved");

  c_commit: cover property (command_i.valid && command_i.code == 8'he7);
  c_refused: cover property (write_refused_o);
  c_word_read: cover property (rd_cmd && command_i.code == 8'h79);
endmodule // fault_status_summary_checker

bind fault_status_summary fault_status_summary_checker u_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .command_i(command_i),
  .output0_status_i(output0_status_i), .output1_status_i(output1_status_i),
  .unit_status_i(unit_status_i), .response_o(response_o), .fall_time0_o(fall_time0_o),
  .fall_time1_o(fall_time1_o), .fault_summary_byte_o(fault_summary_byte_o),
  .fault_summary_word_o(fault_summary_word_o), .write_refused_o(write_refused_o));

/* File: host_model.sv */
// host side model: issues one command per call on the decoded command port
// assumes calls start just after a rising edge
module host_model
  import fault_summary_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire fault_summary_pkg::response_t response_i,
  output fault_summary_pkg::command_t       command_o
);
  timeunit 1ns;
  timeprecision 100ps;
  response_t last_resp;
  initial command_o = '0;
  // ==========================================================================
  // valid stays up so that calls can follow back to back; idle drops it
  task automatic send(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
    command_o = '{1'b1, w, p, c, d};
    @(posedge core_clk_i);
    #1;
    last_resp = response_i;
  endtask
  task automatic idle();
    command_o = '0;
  endtask
endmodule // host_model

/* File: testbench.sv */
// self-checking bench for the fault summary register block
// assumes host_model and the bound checker are compiled before it
module testbench
  import fault_summary_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic           core_clk_i = 1'b0;
  logic           rst_i = 1'b1;
  output_status_t o0, o1;
  unit_status_t   us;
  command_t       cmd;
  response_t      resp;
  logic [15:0]    ft0, ft1, wordv, e;
  logic [7:0]     bytev;
  logic           refused;
  logic [30:0]    base, vec;
  int             mismatches = 0;
  int             comparisons = 0;

  always #12.5 core_clk_i = ~core_clk_i;
  host_model host (.core_clk_i(core_clk_i), .response_i(resp), .command_o(cmd));
  fault_status_summary dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .command_i(cmd),
    .output0_status_i(o0), .output1_status_i(o1), .unit_status_i(us), .response_o(resp),
    .fall_time0_o(ft0), .fall_time1_o(ft1), .fault_summary_byte_o(bytev),
    .fault_summary_word_o(wordv), .write_refused_o(refused));

  // ==========================================================================
  // expected word, worked out from the bit meanings
  function automatic logic [15:0] want(input logic [7:0] a, b, input logic [14:0] x);
    logic [7:0] y;
    y = a | b;
    return {|y[5:3], |y[2:0], x[14] | x[13], x[1], ~(a[6] & b[6]), 4'h0,
            y[7], y[5], y[2], x[13], |x[12:10], |x[9:2], x[0]};
  endfunction
  // wide enough for the paired fall times and the word with the byte
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic p, input logic [17:0] x);
    // valid is left up, so the next call can follow without a second drive in one step
    host.send(1'b0, p, c, 16'h0000);
    check({host.last_resp.valid, host.last_resp.error, host.last_resp.data}, x);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge core_clk_i);
    mismatches++;
    complete_run();
  end

  // ==========================================================================
  // main sequence
  initial begin
    base = {8'h40, 8'h40, 15'h0000};
    {o0, o1, us} = base;
    repeat (8) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    check(ft0, 16'h01f4);
    rd(8'h65, 1'b1, {2'b10, 16'h01f4});
    rd(8'h79, 1'b0, {2'b10, 16'h0000});
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      vec = (i == 31) ? '1 : base ^ (31'h1 << i);
      {o0, o1, us} = vec;
      e = want(vec[30:23], vec[22:15], vec[14:0]);
      rd(8'h79, 1'b0, {2'b10, e});
      rd(8'h78, 1'b1, {2'b10, 8'h00, e[7:0]});
      check({wordv, bytev}, {e, e[7:0]});
    end
    {o0, o1, us} = base;
    $display("summary test done");
    host.send(1'b1, 1'b1, 8'h65, 16'h0123);
    check({ft1, refused}, {16'h01f4, 1'b0});
    rd(8'h65, 1'b1, {2'b10, 16'h0123});
    rd(8'h65, 1'b0, {2'b10, 16'h01f4});
    host.send(1'b1, 1'b0, 8'h65, 16'hffff);
    host.send(1'b1, 1'b0, 8'he7, 16'h0000);
    host.idle();
    check(ft0, 16'h01f4);
    @(posedge core_clk_i);
    #1;
    check({ft0, ft1}, {16'hffff, 16'h0123});
    $display("fall time test done");
    for (int k = 0; k < 2; k++) begin
      host.send(1'b1, 1'b0, 8'h78 + k[7:0], 16'hffff);
      check(refused, 1'b1);
    end
    rd(8'h78, 1'b0, {2'b10, 16'h0000});
    rd(8'h00, 1'b0, {2'b11, 16'h0000});
    $display("refusal test done");
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    check({ft0, ft1}, {16'h01f4, 16'h01f4});
    rd(8'h65, 1'b0, {2'b10, 16'h01f4});
    $display("second reset test done");
    complete_run();
  end
endmodule // testbench
